// >>> common/uvfr_pkg.sv
/*
 holds shared constants and carrier types of the undervoltage fault
 reporter. assumes a single 250 MHz system clock.
*/
package uvfr_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned REPORT_MS = 40;
	localparam int unsigned BLOCK_MS = 80;
	localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
	localparam int unsigned REPORT_CYC = REPORT_MS * CYC_PER_MS;
	localparam int unsigned BLOCK_CYC = BLOCK_MS * CYC_PER_MS;
	localparam int unsigned CNT_W = 25;
	localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
	localparam logic [CNT_W-1:0] CNT_ONE = 25'h0000001;
	localparam logic [1:0] SYNC_RESET = 2'h0;

	typedef enum {
		ST_IDLE,
		ST_REPORT_LOW,
		ST_REPORT_HIGH,
		ST_HOLD_LOW,
		ST_RELEASE_WAIT
	} uvfr_state_e;

	// gate command pair and open-drain status line pins
	typedef struct packed {
		logic gate_off_a;
		logic gate_off_b;
		logic fault_out;
		logic fault_oe_n;
	} uvfr_pins_s;
endpackage

// >>> hw/uvfr_sync.sv
/*
 two-flop synchroniser for the undervoltage detector input.
 assumes the input is asynchronous to mclk.
*/
module uvfr_sync (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic async_in,
	output logic sync_out
);
	logic [1:0] stage;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			stage <= uvfr_pkg::SYNC_RESET;
		end else if (clk_en) begin
			stage <= {stage[0], async_in};
		end
	end

	assign sync_out = stage[1];
endmodule

// >>> hw/uvfr_top.sv
/*
 primary-side undervoltage fault sequencer: blocks both gate outputs and
 drives the open-drain fault status line in a timed pattern.
 assumes an external pull-up on the fault line and a 250 MHz mclk.
*/
// Notes on behaviour
// - fault line released normally, pulled low on fault
// - undervoltage blocks both gates while present and for 80 ms after it clears
// - report 40 ms low then 40 ms high
// - cleared during report leaves line released
// - persisting fault holds low, release 80 ms after
module uvfr_top #(
	parameter int unsigned REPORT_CYCLES = uvfr_pkg::REPORT_CYC,
	parameter int unsigned BLOCK_CYCLES = uvfr_pkg::BLOCK_CYC
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic uv_detect,
	output logic gate_off_a,
	output logic gate_off_b,
	output logic fault_out,
	output logic fault_oe_n
);
	localparam logic [uvfr_pkg::CNT_W-1:0] REPORT_LAST =
		uvfr_pkg::CNT_W'(REPORT_CYCLES - 1);
	localparam logic [uvfr_pkg::CNT_W-1:0] BLOCK_LAST =
		uvfr_pkg::CNT_W'(BLOCK_CYCLES - 1);

	uvfr_pkg::uvfr_state_e state;
	uvfr_pkg::uvfr_state_e next_state;
	logic [uvfr_pkg::CNT_W-1:0] seq_cnt;
	logic [uvfr_pkg::CNT_W-1:0] next_seq_cnt;
	logic [uvfr_pkg::CNT_W-1:0] blk_cnt;
	logic [uvfr_pkg::CNT_W-1:0] next_blk_cnt;
	logic uv_sync;
	logic uv_rise;
	logic uv_prev;
	logic blocking;
	logic next_blocking;
	logic seq_done_low;
	logic seq_done_high;
	logic blk_done;
	logic release_done;
	logic next_pull_low;
	uvfr_pkg::uvfr_pins_s pins;
	uvfr_pkg::uvfr_pins_s next_pins;

	uvfr_sync u_sync (
		.mclk(mclk),
		.arst_n(arst_n),
		.clk_en(clk_en),
		.async_in(uv_detect),
		.sync_out(uv_sync)
	);

	assign uv_rise = uv_sync & ~uv_prev;
	assign seq_done_low = (state == uvfr_pkg::ST_REPORT_LOW) &&
		(seq_cnt == REPORT_LAST);
	assign seq_done_high = (state == uvfr_pkg::ST_REPORT_HIGH) &&
		(seq_cnt == REPORT_LAST);
	assign release_done = (state == uvfr_pkg::ST_RELEASE_WAIT) &&
		(seq_cnt == BLOCK_LAST);
	assign blk_done = blocking && (blk_cnt == BLOCK_LAST);

	// blocking retriggers on every new onset; a present fault keeps it on
	always_comb begin
		next_blocking = blocking;
		next_blk_cnt = blk_cnt;
		if (uv_rise || uv_sync) begin
			next_blocking = 1'b1;
			next_blk_cnt = uvfr_pkg::CNT_ZERO;
		end else if (blocking) begin
			if (blk_done) begin
				next_blocking = 1'b0;
			end else begin
				next_blk_cnt = blk_cnt + uvfr_pkg::CNT_ONE;
			end
		end
	end

	always_comb begin
		next_state = state;
		next_seq_cnt = seq_cnt + uvfr_pkg::CNT_ONE;
		case (state)
			uvfr_pkg::ST_IDLE: begin
				next_seq_cnt = uvfr_pkg::CNT_ZERO;
				if (uv_sync) begin
					next_state = uvfr_pkg::ST_REPORT_LOW;
				end
			end
			uvfr_pkg::ST_REPORT_LOW: begin
				if (seq_done_low) begin
					next_state = uvfr_pkg::ST_REPORT_HIGH;
					next_seq_cnt = uvfr_pkg::CNT_ZERO;
				end
			end
			uvfr_pkg::ST_REPORT_HIGH: begin
				if (seq_done_high) begin
					next_seq_cnt = uvfr_pkg::CNT_ZERO;
					if (uv_sync) begin
						next_state = uvfr_pkg::ST_HOLD_LOW;
					end else begin
						next_state = uvfr_pkg::ST_IDLE;
					end
				end
			end
			uvfr_pkg::ST_HOLD_LOW: begin
				next_seq_cnt = uvfr_pkg::CNT_ZERO;
				if (!uv_sync) begin
					next_state = uvfr_pkg::ST_RELEASE_WAIT;
				end
			end
			uvfr_pkg::ST_RELEASE_WAIT: begin
				// a relapse during the wait returns to holding low
				if (uv_sync) begin
					next_state = uvfr_pkg::ST_HOLD_LOW;
					next_seq_cnt = uvfr_pkg::CNT_ZERO;
				end else if (release_done) begin
					next_state = uvfr_pkg::ST_IDLE;
					next_seq_cnt = uvfr_pkg::CNT_ZERO;
				end
			end
			default: begin
				next_state = uvfr_pkg::ST_IDLE;
				next_seq_cnt = uvfr_pkg::CNT_ZERO;
			end
		endcase
	end

	// line stays low through the 80 ms release wait
	assign next_pull_low = (next_state == uvfr_pkg::ST_REPORT_LOW) ||
		(next_state == uvfr_pkg::ST_HOLD_LOW) ||
		(next_state == uvfr_pkg::ST_RELEASE_WAIT);

	assign next_pins.gate_off_a = next_blocking;
	assign next_pins.gate_off_b = next_blocking;
	assign next_pins.fault_out = 1'b0;
	assign next_pins.fault_oe_n = ~next_pull_low;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state <= uvfr_pkg::ST_IDLE;
			seq_cnt <= uvfr_pkg::CNT_ZERO;
			blk_cnt <= uvfr_pkg::CNT_ZERO;
			blocking <= 1'b0;
			uv_prev <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			seq_cnt <= next_seq_cnt;
			blk_cnt <= next_blk_cnt;
			blocking <= next_blocking;
			uv_prev <= uv_sync;
		end
	end

	// pins released at reset: gates not forced, line high-z
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pins <= '{gate_off_a: 1'b0, gate_off_b: 1'b0,
				fault_out: 1'b0, fault_oe_n: 1'b1};
		end else if (clk_en) begin
			pins <= next_pins;
		end
	end

	assign gate_off_a = pins.gate_off_a;
	assign gate_off_b = pins.gate_off_b;
	assign fault_out = pins.fault_out;
	assign fault_oe_n = pins.fault_oe_n;
endmodule

// >>> testbench/uvfr_ctl.sv
/*
 controller end of the fault line.
 assumes a pull-up on the board side.
*/
module uvfr_ctl (
	input wire logic fault_out,
	input wire logic fault_oe_n,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ps;
	// released line reads the pull-up, never the last driven level
	assign line = fault_oe_n ? 1'h1 : fault_out;
endmodule

// >>> testbench/uvfr_props.sv
/*
 port checker of uvfr_top.
 assumes clk_en held high.
*/
module uvfr_props #(
	parameter int unsigned REPORT_CYCLES = 20,
	parameter int unsigned BLOCK_CYCLES = 40
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire logic uv_detect,
	input wire logic gate_off_a,
	input wire logic gate_off_b,
	input wire logic fault_out,
	input wire logic fault_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	gate_pair_a: assert property (gate_off_a == gate_off_b)
		else $error("gate outputs differ");
	line_low_a: assert property (fault_out == 1'h0)
		else $error("fault line driven high");
	uv_block_a: assert property ($rose(uv_detect) |-> ##3 gate_off_a)
		else $error("gates not blocked in time");
	sync_path_a: assert property ($rose(gate_off_a) |-> $past(uv_detect, 3))
		else $error("gates blocked without cause");
	fall_gate_a: assert property ($fell(fault_oe_n) |-> gate_off_a)
		else $error("fault reported with gates open");
	low_phase_a: assert property ($fell(fault_oe_n) |=> !fault_oe_n[*8])
		else $error("low phase too short");
	high_phase_a: assert property ($rose(fault_oe_n) |=> fault_oe_n[*8])
		else $error("high phase too short");
endmodule

bind uvfr_top uvfr_props #(.REPORT_CYCLES(REPORT_CYCLES),
	.BLOCK_CYCLES(BLOCK_CYCLES)) props_u (.mclk(mclk), .arst_n(arst_n),
	.clk_en(clk_en), .uv_detect(uv_detect), .gate_off_a(gate_off_a),
	.gate_off_b(gate_off_b), .fault_out(fault_out), .fault_oe_n(fault_oe_n));

// >>> testbench/uvfr_top_tb.sv
/*
 self-checking bench of uvfr_top.
 assumes small report and block counts.
*/
module uvfr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int R = 20;
	localparam int B = 40;
	logic mclk = 0, arst_n = 0, clk_en = 1, uv_detect = 0, prev = 1;
	logic ga, gb, fo, foe, line;
	int miscompares = 0, checks = 0, cyc = 0, c, n;
	logic [31:0] q[$];
	initial forever #2 mclk = ~mclk;
	uvfr_top #(.REPORT_CYCLES(R), .BLOCK_CYCLES(B)) dut_u (.mclk(mclk),
		.arst_n(arst_n), .clk_en(clk_en), .uv_detect(uv_detect),
		.gate_off_a(ga), .gate_off_b(gb), .fault_out(fo),
		.fault_oe_n(foe));
	uvfr_ctl ctl_u (.fault_out(fo), .fault_oe_n(foe), .line(line));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wt(input int k);
		repeat (k) @(negedge mclk);
	endtask
	always @(posedge mclk) cyc <= cyc + 1;
	// each line edge settles the oldest note
	always @(negedge mclk) begin
		if (line !== prev) begin
			chk({line, cyc[30:0]}, q.pop_front());
			prev = line;
		end
		if (cyc > 3000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		n = $urandom(32'h0ad163f9);
		wt(12);
		arst_n = 1;
		wt(2);
		chk({ga, gb, line}, 32'h1);
		for (int i = 0; i < 6; i++) begin
			c = cyc;
			uv_detect = 1;
			q.push_back({1'h0, 31'(c + 3)});
			q.push_back({1'h1, 31'(c + 3 + R)});
			if (i % 2) begin
				// glitch cleared inside the report
				wt(1 + $urandom % 5);
				uv_detect = 0;
				wt(2 * R + B + 9);
			end else begin
				q.push_back({1'h0, 31'(c + 3 + 2 * R)});
				wt(2 * R + 4 + $urandom % 8);
				uv_detect = 0;
				q.push_back({1'h1, 31'(cyc + 3 + B)});
				wt(B + 12);
			end
			chk({ga, line}, 32'h1);
		end
		chk(q.size(), 32'h0);
		give_verdict();
	end
endmodule
